// [core/tsc_ctrl.sv]
// Control core of an eight-channel touch sensor: sampler, detector, opcode decoder.
// Assumes an AXI4-Lite master, analog comparators muxed by chan_sel, pins asynchronous.
`timescale 1ns/100ps
`include "tsc_cfg.svh"

module tsc_ctrl (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire tsc_pkg::tsc_axi_req_t axi_req,
	output tsc_pkg::tsc_axi_rsp_t      axi_rsp,
	input  wire logic                  sleep_pin,
	input  wire logic                  address_select_pin,
	input  wire logic                  cmp_ref_first,
	input  wire logic                  cmp_sensor_state_reg_first,
	input  wire logic [7:0]            peer_sensor_state_reg,
	output logic [7:0]                 channel_detect_outputs,
	output logic [2:0]                 chan_sel,
	output logic                       charge_up_pulse,
	output logic                       charge_down_pulse,
	output logic                       int_n,
	output logic                       osc_enable,
	output logic                       regulator_enable,
	output logic                       fast_start
);

	localparam logic [10:0] FAST_CYC = 11'(`TSC_FAST_START_CYC);

	tsc_pkg::tsc_state_t st_ff;
	tsc_pkg::tsc_state_t nxt_st;

	// Maps a byte offset to a register index; bit 2 flags a hit
	function automatic logic [2:0] tsc_dec(input logic [7:0] addr);
		case (addr)
			`TSC_OFS_CMD:  tsc_dec = 3'h4;
			`TSC_OFS_SENSOR_STATE_REG: tsc_dec = 3'h5;
			`TSC_OFS_RDBK: tsc_dec = 3'h6;
			`TSC_OFS_STAT: tsc_dec = 3'h7;
			default:       tsc_dec = 3'h0;
		endcase
	endfunction : tsc_dec

	// Saturating same-direction count, restarting at one on a flip
	function automatic logic [6:0] tsc_count(input logic same, input logic [6:0] c);
		if (!same)
			tsc_count = 7'h01;
		else if (c >= `TSC_DETECT_COUNT)
			tsc_count = `TSC_DETECT_COUNT;
		else
			tsc_count = c + 7'h01;
	endfunction : tsc_count

	// Either cascade role alternates the sensor byte on reads
	function automatic logic tsc_cascade(input logic [7:0] cfg);
		tsc_cascade = (cfg[`TSC_CFG_OPM_LSB +: 2] != 2'h0);
	endfunction : tsc_cascade

	always_comb begin
		logic [2:0]  wdec;
		logic [2:0]  rdec;
		logic [7:0]  opc;
		logic [7:0]  dat;
		logic        do_wr;
		logic        do_cmd;
		logic        soft_rst;
		logic        sensor_state_reg_rd;
		logic        clr_int;
		logic        pin_sleep;
		logic        tick;
		logic [6:0]  c_new;
		logic [7:0]  live;
		logic [7:0]  sensor_state_reg_new;
		logic [7:0]  changed;
		logic [31:0] rd_val;
		logic [1:0]  rd_resp;
		wdec      = 3'h0;
		rdec      = 3'h0;
		opc       = 8'h00;
		dat       = 8'h00;
		do_wr     = 1'b0;
		do_cmd    = 1'b0;
		soft_rst  = 1'b0;
		sensor_state_reg_rd   = 1'b0;
		clr_int   = 1'b0;
		tick      = 1'b0;
		c_new     = 7'h00;
		rd_val    = 32'h0000_0000;
		rd_resp   = 2'h0;
		pin_sleep = 1'b0;
		live      = 8'h00;
		sensor_state_reg_new  = 8'h00;
		changed   = 8'h00;
		nxt_st    = st_ff;

		// Pin inputs: three stages, value moves once stages two and three agree
		nxt_st.s1 = {address_select_pin, cmp_sensor_state_reg_first, cmp_ref_first, sleep_pin};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < 4; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i])
				nxt_st.filt[i] = st_ff.s3[i];
		end
		pin_sleep = st_ff.filt[0];

		// Write channel: address and data taken in either order
		if (axi_req.awvalid && st_ff.axi.awready) begin
			nxt_st.aw_got       = 1'b1;
			nxt_st.aw_addr      = axi_req.awaddr;
			nxt_st.axi.awready  = 1'b0;
		end
		if (axi_req.wvalid && st_ff.axi.wready) begin
			nxt_st.w_got        = 1'b1;
			nxt_st.wdata        = axi_req.wdata;
			nxt_st.wstrb        = axi_req.wstrb;
			nxt_st.axi.wready   = 1'b0;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.axi.bvalid) begin
			wdec               = tsc_dec(st_ff.aw_addr);
			do_wr              = 1'b1;
			nxt_st.axi.bvalid  = 1'b1;
			nxt_st.axi.bresp   = wdec[2] ? 2'h0 : 2'h2;
			nxt_st.aw_got      = 1'b0;
			nxt_st.w_got       = 1'b0;
		end
		if (st_ff.axi.bvalid && axi_req.bready) begin
			nxt_st.axi.bvalid  = 1'b0;
			nxt_st.axi.awready = 1'b1;
			nxt_st.axi.wready  = 1'b1;
		end

		// Only writes to the command word with its low lane carry an opcode
		do_cmd = do_wr && (wdec == 3'h4) && st_ff.wstrb[0];
		opc    = st_ff.wdata[`TSC_CMD_OPC_LSB +: 8];
		dat    = st_ff.wdata[`TSC_CMD_DATA_LSB +: 8];

		// Read channel: one read in flight, data one cycle after the address
		if (axi_req.arvalid && st_ff.axi.arready) begin
			rdec = tsc_dec(axi_req.araddr);
			case (rdec)
				3'h5: begin
					sensor_state_reg_rd = 1'b1;
					if (tsc_cascade(st_ff.config_reg) && st_ff.alt_sel)
						rd_val = {24'h00_0000, peer_sensor_state_reg};
					else
						rd_val = {24'h00_0000, st_ff.sensor_state_reg};
				end
				3'h6: rd_val = {24'h00_0000, st_ff.rdbk};
				3'h7: rd_val = {16'h0000, `TSC_BUS_ADDR_HI, st_ff.filt[3], 4'h0,
				               st_ff.int_over_bus, st_ff.int_flag, pin_sleep, st_ff.sw_sleep};
				3'h4: rd_val = 32'h0000_0000;
				default: rd_resp = 2'h2;
			endcase
			nxt_st.axi.arready = 1'b0;
			nxt_st.axi.rvalid  = 1'b1;
			nxt_st.axi.rdata   = rd_val;
			nxt_st.axi.rresp   = rd_resp;
		end
		if (st_ff.axi.rvalid && axi_req.rready) begin
			nxt_st.axi.rvalid  = 1'b0;
			nxt_st.axi.arready = 1'b1;
		end
		if (sensor_state_reg_rd && tsc_cascade(st_ff.config_reg))
			nxt_st.alt_sel = !st_ff.alt_sel;

		// Opcode decoder; runs whether or not the core sleeps
		if (do_cmd) begin
			case (opc)
				`TSC_OP_SOFT_RESET: soft_rst = 1'b1;
				`TSC_OP_CLEAR_INT:  clr_int = 1'b1;
				`TSC_OP_SLEEP:      nxt_st.sw_sleep = 1'b1;
				`TSC_OP_WAKE:       nxt_st.sw_sleep = 1'b0;
				`TSC_OP_WR_CONFIG:  nxt_st.config_reg = dat;
				`TSC_OP_RD_CONFIG:  nxt_st.rdbk = st_ff.config_reg;
				`TSC_OP_WR_CLOCK:   nxt_st.clock_setting_reg = dat;
				`TSC_OP_RD_CLOCK:   nxt_st.rdbk = st_ff.clock_setting_reg;
				`TSC_OP_WR_MASK:    nxt_st.mask_reg = dat;
				`TSC_OP_RD_MASK:    nxt_st.rdbk = st_ff.mask_reg;
				`TSC_OP_INT_BUS:    nxt_st.int_over_bus = 1'b1;
				default:            ;
			endcase
		end

		// Sleep: the two sources are held apart, either one keeps the core down
		nxt_st.asleep = nxt_st.sw_sleep || pin_sleep;
		if (st_ff.asleep && !nxt_st.asleep) begin
			nxt_st.fast_cnt   = FAST_CYC;
			nxt_st.fast_start = 1'b1;
		end else if (st_ff.fast_cnt != 11'h000) begin
			nxt_st.fast_cnt   = st_ff.fast_cnt - 11'h001;
			nxt_st.fast_start = (st_ff.fast_cnt != 11'h001);
		end

		// Sample divider; halted while asleep since the oscillator is off
		nxt_st.up_p = 1'b0;
		nxt_st.dn_p = 1'b0;
		if (!st_ff.asleep) begin
			if (st_ff.div_cnt == 10'h000) begin
				tick           = 1'b1;
				nxt_st.div_cnt = 10'(({5'h00, st_ff.clock_setting_reg[`TSC_CLK_FRQ_LSB +: 5]}
				                     + 10'h001) * `TSC_DIV_UNIT - 10'h001);
			end else begin
				nxt_st.div_cnt = st_ff.div_cnt - 10'h001;
			end
		end
		if (tick) begin
			nxt_st.chan = st_ff.chan + 3'h1;
			// Reference wins over a tie so a stuck pair cannot fake a release
			if (st_ff.filt[1]) begin
				nxt_st.up_p = 1'b1;
				c_new = tsc_count(st_ff.dir[st_ff.chan], st_ff.cnt[st_ff.chan]);
				nxt_st.dir[st_ff.chan] = 1'b1;
				nxt_st.cnt[st_ff.chan] = c_new;
				if (c_new == `TSC_DETECT_COUNT)
					nxt_st.detect[st_ff.chan] = 1'b1;
			end else if (st_ff.filt[2]) begin
				nxt_st.dn_p = 1'b1;
				c_new = tsc_count(!st_ff.dir[st_ff.chan], st_ff.cnt[st_ff.chan]);
				nxt_st.dir[st_ff.chan] = 1'b0;
				nxt_st.cnt[st_ff.chan] = c_new;
				if (c_new == `TSC_DETECT_COUNT)
					nxt_st.detect[st_ff.chan] = 1'b0;
			end
		end

		// Sensor state: direct follows detect, latching holds until read
		// A read reloads from live detect, so a key still held stays set
		live = nxt_st.detect & st_ff.mask_reg;
		if (st_ff.config_reg[`TSC_CFG_SWM_BIT])
			sensor_state_reg_new = sensor_state_reg_rd ? live : (st_ff.sensor_state_reg | live);
		else
			sensor_state_reg_new = live;
		nxt_st.sensor_state_reg = sensor_state_reg_new;
		changed = sensor_state_reg_new ^ st_ff.sensor_state_reg;
		if (st_ff.config_reg[`TSC_CFG_INTM_BIT])
			changed = changed & sensor_state_reg_new;
		if (clr_int || sensor_state_reg_rd)
			nxt_st.int_flag = 1'b0;
		if (changed != 8'h00)
			nxt_st.int_flag = 1'b1;

		// Soft reset: registers and channel logic only, sleep and bus state survive
		if (soft_rst) begin
			nxt_st.config_reg        = `TSC_CFG_RST;
			nxt_st.clock_setting_reg = `TSC_CLK_RST;
			nxt_st.mask_reg          = `TSC_MASK_RST;
			nxt_st.sensor_state_reg  = `TSC_SENSOR_STATE_REG_RST;
			nxt_st.rdbk              = 8'h00;
			nxt_st.int_flag          = 1'b0;
			nxt_st.int_over_bus      = 1'b0;
			nxt_st.alt_sel           = 1'b0;
			nxt_st.dir               = 8'h00;
			nxt_st.cnt               = '0;
			nxt_st.detect            = 8'h00;
			// Sampling pointer keeps stepping; a jump would break the channel order
		end

		// Pin interrupt silent in bus-interrupt mode
		nxt_st.int_n  = !(nxt_st.int_flag && !nxt_st.int_over_bus);
		nxt_st.osc_en = !nxt_st.asleep;
		// Regulator also follows its configuration bit, which soft reset restores
		nxt_st.reg_en = !nxt_st.asleep && !nxt_st.config_reg[`TSC_CFG_VROF_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Every field named, so none can come out of reset unknown
			// Synchronisers start low; a pin already high shows up four edges later
			st_ff.s1                <= 4'h0;
			st_ff.s2                <= 4'h0;
			st_ff.s3                <= 4'h0;
			st_ff.filt              <= 4'h0;
			st_ff.axi.awready       <= 1'b1;
			st_ff.axi.wready        <= 1'b1;
			st_ff.axi.bvalid        <= 1'b0;
			st_ff.axi.bresp         <= 2'h0;
			st_ff.axi.arready       <= 1'b1;
			st_ff.axi.rvalid        <= 1'b0;
			st_ff.axi.rdata         <= 32'h0000_0000;
			st_ff.axi.rresp         <= 2'h0;
			st_ff.aw_got            <= 1'b0;
			st_ff.aw_addr           <= 8'h00;
			st_ff.w_got             <= 1'b0;
			st_ff.wdata             <= 32'h0000_0000;
			st_ff.wstrb             <= 4'h0;
			st_ff.config_reg        <= `TSC_CFG_RST;
			st_ff.clock_setting_reg <= `TSC_CLK_RST;
			st_ff.mask_reg          <= `TSC_MASK_RST;
			st_ff.sensor_state_reg  <= `TSC_SENSOR_STATE_REG_RST;
			st_ff.rdbk              <= 8'h00;
			st_ff.int_flag          <= 1'b0;
			st_ff.int_over_bus      <= 1'b0;
			st_ff.sw_sleep          <= 1'b0;
			st_ff.alt_sel           <= 1'b0;
			st_ff.asleep            <= 1'b0;
			st_ff.fast_cnt          <= 11'h000;
			st_ff.fast_start        <= 1'b0;
			st_ff.div_cnt           <= 10'h000;
			st_ff.chan              <= 3'h0;
			st_ff.dir               <= 8'h00;
			st_ff.cnt               <= '0;
			st_ff.detect            <= 8'h00;
			st_ff.up_p              <= 1'b0;
			st_ff.dn_p              <= 1'b0;
			st_ff.int_n             <= 1'b1;
			st_ff.osc_en            <= 1'b1;
			st_ff.reg_en            <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign axi_rsp                = st_ff.axi;
	assign channel_detect_outputs = st_ff.detect;
	assign chan_sel               = st_ff.chan;
	assign charge_up_pulse        = st_ff.up_p;
	assign charge_down_pulse      = st_ff.dn_p;
	assign int_n                  = st_ff.int_n;
	assign osc_enable             = st_ff.osc_en;
	assign regulator_enable       = st_ff.reg_en;
	assign fast_start             = st_ff.fast_start;

endmodule : tsc_ctrl

// [core/tsc_cfg.svh]
// Offsets, reset values, opcodes and timing counts of the touch sensor core.
// Assumes the includer wants plain text macros; no logic lives here.
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

`define TSC_OFS_CMD        8'h00
`define TSC_OFS_SENSOR_STATE_REG       8'h04
`define TSC_OFS_RDBK       8'h08
`define TSC_OFS_STAT       8'h0C

`define TSC_CMD_OPC_LSB    0
`define TSC_CMD_DATA_LSB   8

`define TSC_CFG_RST        8'h00
`define TSC_CLK_RST        8'h0C
`define TSC_MASK_RST       8'hFF
`define TSC_SENSOR_STATE_REG_RST       8'h00

`define TSC_CFG_OPM_LSB    6
`define TSC_CFG_SWM_BIT    5
`define TSC_CFG_VROF_BIT   2
`define TSC_CFG_INTM_BIT   1
`define TSC_CLK_FRQ_LSB    0

`define TSC_OP_SOFT_RESET  8'h00
`define TSC_OP_CLEAR_INT   8'h03
`define TSC_OP_SLEEP       8'h05
`define TSC_OP_WAKE        8'h06
`define TSC_OP_WR_CONFIG   8'h30
`define TSC_OP_RD_CONFIG   8'h33
`define TSC_OP_WR_CLOCK    8'h35
`define TSC_OP_RD_CLOCK    8'h36
`define TSC_OP_WR_MASK     8'h39
`define TSC_OP_RD_MASK     8'h3A
`define TSC_OP_INT_BUS     8'h3C

`define TSC_BUS_ADDR_HI    7'h1D
`define TSC_DETECT_COUNT   7'h40
`define TSC_DIV_UNIT       10'h010

`define TSC_CLK_PERIOD_NS  8
`define TSC_FAST_START_NS  10000
`define TSC_FAST_START_CYC ((`TSC_FAST_START_NS + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)

`endif

// [core/tsc_pkg.sv]
// Types of the touch sensor core: bus carriers and the whole-module state.
// Assumes tsc_cfg.svh supplies the numbers.
package tsc_pkg;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} tsc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tsc_axi_rsp_t;

	typedef struct packed {
		logic [3:0]      s1;
		logic [3:0]      s2;
		logic [3:0]      s3;
		logic [3:0]      filt;
		tsc_axi_rsp_t    axi;
		logic            aw_got;
		logic [7:0]      aw_addr;
		logic            w_got;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		logic [7:0]      config_reg;
		logic [7:0]      clock_setting_reg;
		logic [7:0]      mask_reg;
		logic [7:0]      sensor_state_reg;
		logic [7:0]      rdbk;
		logic            int_flag;
		logic            int_over_bus;
		logic            sw_sleep;
		logic            alt_sel;
		logic            asleep;
		logic [10:0]     fast_cnt;
		logic            fast_start;
		logic [9:0]      div_cnt;
		logic [2:0]      chan;
		logic [7:0]      dir;
		logic [7:0][6:0] cnt;
		logic [7:0]      detect;
		logic            up_p;
		logic            dn_p;
		logic            int_n;
		logic            osc_en;
		logic            reg_en;
	} tsc_state_t;

endpackage : tsc_pkg

// [tb/tsc_touch_model.sv]
// Far-side model of the sense plates and comparators of the touch sensor core.
// Assumes chan_sel selects the plate; touched is set by the bench per channel.
`timescale 1ns/100ps
module tsc_touch_model (
	input  wire logic [2:0] chan_sel,
	input  wire logic [7:0] touched,
	output logic            cmp_ref_first,
	output logic            cmp_sensor_state_reg_first
);
	// Touched plate discharges slower, so the reference comparator wins
	assign cmp_ref_first  = touched[chan_sel];
	assign cmp_sensor_state_reg_first = !touched[chan_sel];
endmodule : tsc_touch_model

// [tb/tsc_ctrl_props_props.sv]
// Concurrent checks on the ports of the touch sensor control core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module tsc_ctrl_props (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire tsc_pkg::tsc_axi_req_t axi_req,
	input wire tsc_pkg::tsc_axi_rsp_t axi_rsp,
	input wire logic [2:0]            chan_sel,
	input wire logic                  charge_up_pulse,
	input wire logic                  charge_down_pulse,
	input wire logic                  osc_enable,
	input wire logic                  regulator_enable,
	input wire logic                  fast_start
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_bhold;
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	property p_rhold;
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_rans;
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
	endproperty
	a_rans: assert property (p_rans) else $error("read not answered");
	property p_wbusy;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
	property p_dir;
		charge_up_pulse |-> !charge_down_pulse ##1 !charge_up_pulse;
	endproperty
	a_dir: assert property (p_dir) else $error("bad pulse");
	property p_step;
		$changed(chan_sel) |-> chan_sel == $past(chan_sel) + 3'h1;
	endproperty
	a_step: assert property (p_step) else $error("channel skipped");
	property p_quiet;
		!osc_enable && !$past(osc_enable) |-> !charge_up_pulse && !charge_down_pulse
			&& $stable(chan_sel);
	endproperty
	a_quiet: assert property (p_quiet) else $error("activity asleep");
	property p_reg;
		!osc_enable && !$past(osc_enable) |-> !regulator_enable;
	endproperty
	a_reg: assert property (p_reg) else $error("regulator on asleep");
	property p_fast;
		$rose(osc_enable) |-> ##[0:2] fast_start;
	endproperty
	a_fast: assert property (p_fast) else $error("no fast start");
endmodule : tsc_ctrl_props

bind tsc_ctrl tsc_ctrl_props i_tsc_ctrl_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.axi_req(axi_req),
	.axi_rsp(axi_rsp),
	.chan_sel(chan_sel),
	.charge_up_pulse(charge_up_pulse),
	.charge_down_pulse(charge_down_pulse),
	.osc_enable(osc_enable),
	.regulator_enable(regulator_enable),
	.fast_start(fast_start)
);

// [tb/test_touch_sensor_command_ctrl.sv]
// Self-checking bench of the touch sensor control core over AXI4-Lite.
// Assumes the comparator model in tsc_touch_model and a 125 MHz clock.
`timescale 1ns/100ps
module test_touch_sensor_command_ctrl;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	tsc_pkg::tsc_axi_req_t req = '0;
	tsc_pkg::tsc_axi_rsp_t rsp;
	logic                  sleep_pin = 1'b0;
	logic                  a_sel = 1'b1;
	logic [2:0]            chan;
	logic [7:0]            touched = 8'h00;
	logic                  ref_first;
	logic                  sensor_state_reg_first;
	logic [7:0]            detect;
	logic                  int_n;
	logic                  osc_en;
	logic                  reg_en;
	logic                  fast;
	logic [31:0]           rd;
	logic [1:0]            rs;
	int                    err_total = 0;
	int                    comparisons = 0;

	always #4 aclk = ~aclk;

	tsc_ctrl i_tsc_ctrl (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.sleep_pin(sleep_pin), .address_select_pin(a_sel), .cmp_ref_first(ref_first),
		.cmp_sensor_state_reg_first(sensor_state_reg_first), .peer_sensor_state_reg(8'hA5), .channel_detect_outputs(detect),
		.chan_sel(chan), .charge_up_pulse(), .charge_down_pulse(), .int_n(int_n),
		.osc_enable(osc_en), .regulator_enable(reg_en), .fast_start(fast));
	tsc_touch_model i_tsc_touch_model (.chan_sel(chan), .touched(touched),
		.cmp_ref_first(ref_first), .cmp_sensor_state_reg_first(sensor_state_reg_first));

	task automatic end_sim;
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic hang(input string what);
		err_total++;
		$display("CHECK FAILED %s expected answer seen timeout", what);
		end_sim();
	endtask : hang

	// Sampled at the falling edge, where the values of the coming rising edge are settled
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		logic tb;
		logic bv;
		int   n;
		n = 0;
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hF;
		do begin
			@(negedge aclk);
			ta = req.awvalid & rsp.awready;
			tw = req.wvalid & rsp.wready;
			tb = req.bready & rsp.bvalid;
			bv = rsp.bvalid;
			@(posedge aclk);
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
			// Ready follows the answer, so the slave has to hold it a cycle
			if (tb)
				req.bready <= 1'b0;
			else if (bv)
				req.bready <= 1'b1;
			n++;
		end while (!tb && n < 64);
		if (!tb) hang("write");
	endtask : axw

	task automatic axr(input logic [7:0] a);
		logic ta;
		logic tr;
		logic rv;
		int   n;
		n = 0;
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		do begin
			@(negedge aclk);
			ta = req.arvalid & rsp.arready;
			tr = req.rready & rsp.rvalid;
			rd = rsp.rdata;
			rs = rsp.rresp;
			rv = rsp.rvalid;
			@(posedge aclk);
			if (ta) req.arvalid <= 1'b0;
			if (tr)
				req.rready <= 1'b0;
			else if (rv)
				req.rready <= 1'b1;
			n++;
		end while (!tr && n < 64);
		if (!tr) hang("read");
	endtask : axr

	task automatic cmd(input logic [7:0] op, input logic [7:0] d);
		axw(8'h00, {16'h0000, d, op});
	endtask : cmd

	task automatic rdbk(input logic [7:0] op, input logic [31:0] exp, input string what);
		cmd(op, 8'h00);
		axr(8'h08);
		chk(what, rd, exp);
	endtask : rdbk

	// Pins are read at the falling edge, clear of the edge that launches them
	task automatic wait_osc(input logic e);
		int n;
		n = 0;
		@(negedge aclk);
		while (n < 40 && osc_en !== e) begin
			@(negedge aclk);
			n++;
		end
		chk("osc_enable", {31'h0, osc_en}, {31'h0, e});
		@(posedge aclk);
	endtask : wait_osc

	// Returns at a falling edge; the caller moves on to the rising one
	task automatic wait_det(input logic [7:0] e);
		int n;
		n = 0;
		@(negedge aclk);
		while (n < 12000 && detect !== e) begin
			@(negedge aclk);
			n++;
		end
		if (n == 12000) hang("detect");
	endtask : wait_det

	task automatic t_regs;
		rdbk(8'h33, 32'h00, "config reset");
		rdbk(8'h36, 32'h0C, "clock reset");
		rdbk(8'h3A, 32'hFF, "mask reset");
		cmd(8'h30, 8'h24);
		cmd(8'h35, 8'h1F);
		cmd(8'h39, 8'h5A);
		cmd(8'h31, 8'hFF);
		cmd(8'h37, 8'h00);
		rdbk(8'h33, 32'h24, "config");
		rdbk(8'h36, 32'h1F, "clock");
		rdbk(8'h3A, 32'h5A, "mask");
		@(negedge aclk);
		chk("regulator off", {31'h0, reg_en}, 32'h0);
		@(posedge aclk);
		axr(8'h40);
		chk("unmapped resp", {30'h0, rs}, 32'h2);
		cmd(8'h3C, 8'h00);
		axr(8'h0C);
		chk("bus address", {24'h0, rd[15:8]}, 32'h3B);
		chk("int over bus", {31'h0, rd[3]}, 32'h1);
		a_sel <= 1'b0;
		repeat (8) @(posedge aclk);
		axr(8'h0C);
		chk("bus address low", {24'h0, rd[15:8]}, 32'h3A);
		cmd(8'h30, 8'h84);
		axr(8'h04);
		chk("own byte", rd, 32'h00);
		axr(8'h04);
		chk("peer byte", rd, 32'hA5);
		cmd(8'h00, 8'h00);
		rdbk(8'h36, 32'h0C, "clock soft reset");
		rdbk(8'h3A, 32'hFF, "mask soft reset");
		rdbk(8'h33, 32'h00, "config soft reset");
		axr(8'h0C);
		chk("int over bus off", {31'h0, rd[3]}, 32'h0);
		@(negedge aclk);
		chk("regulator on", {31'h0, reg_en}, 32'h1);
		@(posedge aclk);
	endtask : t_regs

	task automatic t_sleep;
		cmd(8'h05, 8'h00);
		wait_osc(1'b0);
		sleep_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		sleep_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		@(negedge aclk);
		chk("pin cannot wake", {31'h0, osc_en}, 32'h0);
		@(posedge aclk);
		rdbk(8'h36, 32'h0C, "clock asleep");
		cmd(8'h06, 8'h00);
		wait_osc(1'b1);
		@(negedge aclk);
		chk("fast start", {31'h0, fast}, 32'h1);
		@(posedge aclk);
		sleep_pin <= 1'b1;
		wait_osc(1'b0);
		cmd(8'h06, 8'h00);
		repeat (10) @(posedge aclk);
		@(negedge aclk);
		chk("command cannot wake", {31'h0, osc_en}, 32'h0);
		@(posedge aclk);
		sleep_pin <= 1'b0;
		wait_osc(1'b1);
	endtask : t_sleep

	// Fastest sample period keeps the 64-sample filter within the run budget
	task automatic t_touch;
		cmd(8'h35, 8'h00);
		touched <= 8'h04;
		repeat (4000) @(posedge aclk);
		@(negedge aclk);
		chk("early detect", {24'h0, detect}, 32'h0);
		@(posedge aclk);
		wait_det(8'h04);
		chk("press int", {31'h0, int_n}, 32'h0);
		@(posedge aclk);
		cmd(8'h03, 8'h00);
		@(negedge aclk);
		chk("int cleared", {31'h0, int_n}, 32'h1);
		@(posedge aclk);
		axr(8'h04);
		chk("sensor byte", rd, 32'h04);
		touched <= 8'h00;
		wait_det(8'h00);
		chk("release int", {31'h0, int_n}, 32'h0);
		@(posedge aclk);
		axr(8'h04);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk("read clears int", {31'h0, int_n}, 32'h1);
		@(posedge aclk);
	endtask : t_touch

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_sleep();
		t_touch();
		end_sim();
	end
endmodule : test_touch_sensor_command_ctrl
